// *** hw/disk_page_params.svh ***
`ifndef DISK_PAGE_PARAMS_SVH
`define DISK_PAGE_PARAMS_SVH

// =====================================================
// page identity
`define RECON_PAGE_CODE 6'h02
`define RECON_PAGE_LEN 8'h0a
`define FMT_PAGE_CODE 6'h03
`define FMT_PAGE_LEN 8'h16

// =====================================================
// byte offsets of the reconnect page; code and length offsets shared by both pages
`define OFS_CODE 5'h00
`define OFS_LEN 5'h01
`define OFS_FILL 5'h02
`define OFS_DRAIN 5'h03
`define OFS_RECON_LAST 5'h0b

// =====================================================
// byte offsets of the format page
`define OFS_ZONE_TRK 5'h02
`define OFS_SPARE_SEC 5'h04
`define OFS_SPARE_TZ 5'h06
`define OFS_SPARE_TU 5'h08
`define OFS_SPT 5'h0a
`define OFS_SECT_BYTES 5'h0c
`define OFS_INTERLEAVE 5'h0e
`define OFS_TRK_SKEW 5'h10
`define OFS_CYL_SKEW 5'h12
`define OFS_FLAGS 5'h14
`define OFS_FMT_LAST 5'h17

// =====================================================
// fixed format page values
`define VAL_ZONE_TRK 16'h0004
`define VAL_SPARE_SEC 16'h0001
`define VAL_SPARE_TRK 16'h0000
`define VAL_SPT 16'h0000
`define VAL_SECT_BYTES 16'h0200
`define VAL_INTERLEAVE 16'h0001
`define VAL_TRK_SKEW 16'h001c
`define VAL_CYL_SKEW 16'h0020
`define FLAG_SSEC 7
`define FLAG_HSEC 6
`define FLAG_RMB 5
`define FLAG_SURF 4

// =====================================================
// reset values and transfer granule
`define RST_FILL 8'h00
`define RST_DRAIN 8'h00
`define GRANULE 32'h0000_0200
`define RATIO_SHIFT 8

`endif

// *** hw/disk_page_pkg.sv ***
package disk_page_pkg;

  // =====================================================
  // page selection
  typedef enum {
    PAGE_NONE,
    PAGE_RECON,
    PAGE_FORMAT
  } page_e;

  // =====================================================
  // all state of the page block
  typedef struct packed {
    logic [7:0] fillRatio;
    logic [7:0] drainRatio;
    logic [7:0] rdData;
    logic rdValid;
    logic rdErr;
    logic wrIgnored;
    logic disconnectReq;
    logic reconnectReq;
    logic [31:0] fillBytes;
    logic [31:0] drainBytes;
    logic [15:0] userSectors;
  } state_s;

endpackage : disk_page_pkg

// *** hw/disk_reconnect_format_pages.sv ***
`timescale 1ns/1ns
`include "disk_page_params.svh"

// Function
// - reconnect page: code 02h, length 0Ah, bytes 4 to 11 read zero
// - during reads, disconnect whenever the buffer holds no data
// - fill ratio stored and read back, ignored by reconnect logic
// - drain ratio stored and read back; device picks write reconnect point
// - at least 512 bytes, or the whole shorter remainder, buffered before reconnecting for read data
// - fill threshold rounds down, drain rounds up, to 512 bytes
// - format page: code 03h, length 16h, bytes 21 to 23 read zero
// - format bytes 2 to 9 keep defaults; written values are discarded
// - four tracks per defect zone
// - format unit keeps one spare sector per zone
// - spare tracks per zone and per unit read zero
// - sectors per track reads zero, meaning 52 to 91 varies
// - 512 data bytes per physical sector, whatever the block length
// - interleave reads one
// - track skew of 28 wedges in every zone
// - cylinder skew of 32 wedges in every zone
// - soft sector flag zero, hard sector flag one
// - removable flag reads zero
// - surface flag zero, addresses fill a cylinder first
module disk_reconnect_format_pages #(
  parameter int unsigned BUF_BYTES = 32'd65536,
  parameter int unsigned LEN_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [5:0] pageCode,
  input wire logic [4:0] byteAddr,
  input wire logic rdEn,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic rdErr,
  output logic wrIgnored,
  input wire logic readActive,
  input wire logic writeActive,
  input wire logic [LEN_W-1:0] bufLevel,
  input wire logic [LEN_W-1:0] bufFree,
  input wire logic [LEN_W-1:0] xferRemain,
  output logic disconnectReq,
  output logic reconnectReq,
  output logic [31:0] fillBytes,
  output logic [31:0] drainBytes,
  input wire logic formatActive,
  input wire logic [15:0] zoneSectors,
  output logic [15:0] userSectors
);

  // =====================================================
  // elaboration checks
  if (BUF_BYTES < `GRANULE || (BUF_BYTES % `GRANULE) != 0) begin : g_bufCheck
    $error("buffer size must be a nonzero multiple of the granule");
  end
  if (LEN_W < 10 || LEN_W > 32) begin : g_lenCheck
    $error("length width out of range");
  end

  // =====================================================
  // decoding helpers
  function automatic disk_page_pkg::page_e pageOf(input logic [5:0] code);
    disk_page_pkg::page_e kind;
    kind = disk_page_pkg::PAGE_NONE;
    if (code == `RECON_PAGE_CODE) begin
      kind = disk_page_pkg::PAGE_RECON;
    end else if (code == `FMT_PAGE_CODE) begin
      kind = disk_page_pkg::PAGE_FORMAT;
    end
    return kind;
  endfunction : pageOf

  function automatic logic [7:0] hiLo(input logic [15:0] v, input logic lowByte);
    return lowByte ? v[7:0] : v[15:8];
  endfunction : hiLo

  function automatic logic [7:0] reconByte(input logic [4:0] a, input logic [7:0] fill,
                                           input logic [7:0] drain);
    logic [7:0] b;
    b = 8'h00;
    case (a)
      `OFS_CODE: b = {2'b00, `RECON_PAGE_CODE};
      `OFS_LEN: b = `RECON_PAGE_LEN;
      `OFS_FILL: b = fill;
      `OFS_DRAIN: b = drain;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : reconByte

  function automatic logic [7:0] formatByte(input logic [4:0] a);
    logic [7:0] b;
    logic lo;
    b = 8'h00;
    lo = a[0];
    case ({a[4:1], 1'b0})
      `OFS_CODE: b = lo ? `FMT_PAGE_LEN : {2'b00, `FMT_PAGE_CODE};
      `OFS_ZONE_TRK: b = hiLo(`VAL_ZONE_TRK, lo);
      `OFS_SPARE_SEC: b = hiLo(`VAL_SPARE_SEC, lo);
      `OFS_SPARE_TZ: b = hiLo(`VAL_SPARE_TRK, lo);
      `OFS_SPARE_TU: b = hiLo(`VAL_SPARE_TRK, lo);
      `OFS_SPT: b = hiLo(`VAL_SPT, lo);
      `OFS_SECT_BYTES: b = hiLo(`VAL_SECT_BYTES, lo);
      `OFS_INTERLEAVE: b = hiLo(`VAL_INTERLEAVE, lo);
      `OFS_TRK_SKEW: b = hiLo(`VAL_TRK_SKEW, lo);
      `OFS_CYL_SKEW: b = hiLo(`VAL_CYL_SKEW, lo);
      `OFS_FLAGS: begin
        if (!lo) begin
          b = 8'h00;
          b[`FLAG_SSEC] = 1'b0;
          b[`FLAG_HSEC] = 1'b1;
          b[`FLAG_RMB] = 1'b0;
          b[`FLAG_SURF] = 1'b0;
        end
      end
      default: b = 8'h00;
    endcase
    return b;
  endfunction : formatByte

  // =====================================================
  // read range helper
  // offsets past the page end answer zero with an error flag
  function automatic logic pastEnd(input disk_page_pkg::page_e kind, input logic [4:0] a);
    logic bad;
    bad = 1'b1;
    case (kind)
      disk_page_pkg::PAGE_RECON: bad = (a > `OFS_RECON_LAST);
      disk_page_pkg::PAGE_FORMAT: bad = (a > `OFS_FMT_LAST);
      default: bad = 1'b1;
    endcase
    return bad;
  endfunction : pastEnd

  // =====================================================
  // threshold helpers
  // scale a ratio byte to a byte count of the whole buffer
  function automatic logic [39:0] scaleRatio(input logic [7:0] ratio);
    logic [39:0] prod;
    prod = 40'(ratio) * 40'(BUF_BYTES);
    return prod >> `RATIO_SHIFT;
  endfunction : scaleRatio

  // clear the bits below one granule
  function automatic logic [31:0] roundDown(input logic [39:0] v);
    logic [31:0] low;
    low = v[31:0];
    return low & ~(`GRANULE - 32'd1);
  endfunction : roundDown

  // lift to the next whole granule unless already aligned
  function automatic logic [31:0] roundUp(input logic [39:0] v);
    logic [39:0] lifted;
    lifted = v + 40'(`GRANULE) - 40'd1;
    return roundDown(lifted);
  endfunction : roundUp

  // =====================================================
  // reconnect helpers, deliberately blind to the stored ratios
  // nothing left to move in the current direction
  function automatic logic bufStall(input logic [LEN_W-1:0] v);
    return v == '0;
  endfunction : bufStall

  // a short tail may reconnect once all of it fits
  function automatic logic tailReady(input logic [LEN_W-1:0] avail,
                                     input logic [LEN_W-1:0] remain);
    logic ok;
    ok = 1'b0;
    if (remain != '0 && avail >= remain) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : tailReady

  // read side: one full sector buffered, or the whole short tail
  function automatic logic readReconnect(input logic [LEN_W-1:0] level,
                                         input logic [LEN_W-1:0] remain,
                                         input logic [LEN_W-1:0] gran);
    logic ok;
    ok = (level >= gran);
    if (remain < gran && tailReady(level, remain)) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : readReconnect

  // write side: room for one sector, or room for the whole remainder
  function automatic logic writeReconnect(input logic [LEN_W-1:0] free,
                                          input logic [LEN_W-1:0] remain,
                                          input logic [LEN_W-1:0] gran);
    logic ok;
    ok = (free >= gran);
    if (tailReady(free, remain)) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : writeReconnect

  // =====================================================
  // format helper
  // sectors left to the initiator once the spare is withheld
  function automatic logic [15:0] spareAdjust(input logic [15:0] zs);
    logic [15:0] left;
    left = 16'h0000;
    if (zs > `VAL_SPARE_SEC) begin
      left = zs - `VAL_SPARE_SEC;
    end
    return left;
  endfunction : spareAdjust

  // =====================================================
  // format page image, one constant byte per offset
  localparam int unsigned FMT_BYTES = int'(`OFS_FMT_LAST) + 1;
  logic [7:0] fmtImage [FMT_BYTES];
  for (genvar i = 0; i < FMT_BYTES; i++) begin : g_fmtImage
    assign fmtImage[i] = formatByte(5'(i));
  end

  // =====================================================
  // state
  disk_page_pkg::state_s stateFf;
  disk_page_pkg::state_s nxtState;

  disk_page_pkg::page_e rdKind;
  disk_page_pkg::page_e wrKind;
  logic [LEN_W-1:0] granule;

  assign rdKind = pageOf(pageCode);
  assign wrKind = pageOf(pageCode);
  assign granule = LEN_W'(`GRANULE);

  // =====================================================
  // next state
  always_comb begin
    nxtState = stateFf;
    nxtState.rdValid = 1'b0;
    nxtState.rdErr = 1'b0;
    nxtState.wrIgnored = 1'b0;

    // page reads, one cycle latency
    if (rdEn) begin
      nxtState.rdValid = 1'b1;
      case (rdKind)
        disk_page_pkg::PAGE_RECON: begin
          nxtState.rdData = (byteAddr <= `OFS_RECON_LAST) ?
              reconByte(byteAddr, stateFf.fillRatio, stateFf.drainRatio) : 8'h00;
          nxtState.rdErr = pastEnd(rdKind, byteAddr);
        end
        disk_page_pkg::PAGE_FORMAT: begin
          nxtState.rdData = (byteAddr <= `OFS_FMT_LAST) ? fmtImage[byteAddr] : 8'h00;
          nxtState.rdErr = pastEnd(rdKind, byteAddr);
        end
        default: begin
          nxtState.rdData = 8'h00;
          nxtState.rdErr = 1'b1;
        end
      endcase
    end

    // page writes
    if (wrEn) begin
      case (wrKind)
        disk_page_pkg::PAGE_RECON: begin
          if (byteAddr == `OFS_FILL) begin
            nxtState.fillRatio = wrData;
          end else if (byteAddr == `OFS_DRAIN) begin
            nxtState.drainRatio = wrData;
          end else begin
            nxtState.wrIgnored = 1'b1;
          end
        end
        disk_page_pkg::PAGE_FORMAT: begin
          nxtState.wrIgnored = 1'b1;
        end
        default: begin
          nxtState.wrIgnored = 1'b1;
        end
      endcase
    end

    // threshold rounding to whole sectors
    nxtState.fillBytes = roundDown(scaleRatio(stateFf.fillRatio));
    nxtState.drainBytes = roundUp(scaleRatio(stateFf.drainRatio));

    // reconnect decision, independent of the stored ratios
    nxtState.disconnectReq = 1'b0;
    nxtState.reconnectReq = 1'b0;
    if (readActive) begin
      nxtState.disconnectReq = bufStall(bufLevel);
      nxtState.reconnectReq = readReconnect(bufLevel, xferRemain, granule);
    end else if (writeActive) begin
      nxtState.disconnectReq = bufStall(bufFree);
      nxtState.reconnectReq = writeReconnect(bufFree, xferRemain, granule);
    end

    // one spare sector withheld per zone while formatting
    if (formatActive) begin
      nxtState.userSectors = spareAdjust(zoneSectors);
    end
  end

  // =====================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stateFf <= '0;
      stateFf.fillRatio <= `RST_FILL;
      stateFf.drainRatio <= `RST_DRAIN;
    end else begin
      stateFf <= nxtState;
    end
  end

  // =====================================================
  // outputs
  assign rdData = stateFf.rdData;
  assign rdValid = stateFf.rdValid;
  assign rdErr = stateFf.rdErr;
  assign wrIgnored = stateFf.wrIgnored;
  assign disconnectReq = stateFf.disconnectReq;
  assign reconnectReq = stateFf.reconnectReq;
  assign fillBytes = stateFf.fillBytes;
  assign drainBytes = stateFf.drainBytes;
  assign userSectors = stateFf.userSectors;

endmodule : disk_reconnect_format_pages

// *** test/initiator_model.sv ***
`timescale 1ns/1ns
// ==========
// initiator side of the page access port
module initiator_model (
  input wire logic clk,
  output logic [5:0] pageCode,
  output logic [4:0] byteAddr,
  output logic rdEn,
  output logic wrEn,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic rdErr,
  input wire logic wrIgnored
);
  initial begin
    pageCode = 6'h00;
    byteAddr = 5'h00;
    rdEn = 1'b0;
    wrEn = 1'b0;
    wrData = 8'h00;
  end
  // mode sense reads one byte a request
  task automatic rd(input logic [5:0] pg, input logic [4:0] a, output logic [7:0] d,
                    output logic e);
    @(posedge clk);
    #1;
    pageCode = pg;
    byteAddr = a;
    rdEn = 1'b1;
    @(posedge clk);
    #1;
    rdEn = 1'b0;
    byteAddr = ~a;
    d = (rdValid === 1'b1) ? rdData : 8'hxx;
    e = rdErr;
  endtask : rd
  // mode select writes one byte a request
  task automatic wr(input logic [5:0] pg, input logic [4:0] a, input logic [7:0] d,
                    output logic ign);
    @(posedge clk);
    #1;
    pageCode = pg;
    byteAddr = a;
    wrData = d;
    wrEn = 1'b1;
    @(posedge clk);
    #1;
    wrEn = 1'b0;
    wrData = ~d;
    ign = wrIgnored;
  endtask : wr
endmodule : initiator_model

// *** test/disk_pages_checker.sv ***
`timescale 1ns/1ns
// ==========
// timing checks of the page block
module disk_pages_checker #(
  parameter int unsigned LEN_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [5:0] pageCode,
  input wire logic [4:0] byteAddr,
  input wire logic rdEn,
  input wire logic wrEn,
  input wire logic rdValid,
  input wire logic wrIgnored,
  input wire logic readActive,
  input wire logic [LEN_W-1:0] bufLevel,
  input wire logic [LEN_W-1:0] xferRemain,
  input wire logic disconnectReq,
  input wire logic reconnectReq,
  input wire logic [31:0] fillBytes,
  input wire logic [31:0] drainBytes,
  input wire logic formatActive,
  input wire logic [15:0] zoneSectors,
  input wire logic [15:0] userSectors
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_empty; readActive && bufLevel == '0; endsequence
  sequence s_fmtWr; wrEn && pageCode == 6'h03; endsequence
  property p_rdAns; rdEn |=> rdValid; endproperty
  property p_fmtKeep; s_fmtWr |=> wrIgnored; endproperty
  property p_ratioWr; wrEn && pageCode == 6'h02 && byteAddr[4:1] == 4'h1 |=> !wrIgnored; endproperty
  property p_disc; s_empty |=> disconnectReq && !reconnectReq; endproperty
  property p_minFill; readActive && bufLevel < 512 && xferRemain >= 512 |=> !reconnectReq; endproperty
  property p_full; readActive && bufLevel >= 512 |=> reconnectReq; endproperty
  property p_round; fillBytes[8:0] == 9'h000 && drainBytes[8:0] == 9'h000; endproperty
  property p_spare;
    formatActive && zoneSectors > 16'h0001 |=> userSectors == $past(zoneSectors) - 16'h0001;
  endproperty
  a_rdAns: assert property (p_rdAns) else $error("read answer missing");
  a_fmtKeep: assert property (p_fmtKeep) else $error("format write kept");
  a_ratioWr: assert property (p_ratioWr) else $error("ratio write dropped");
  a_disc: assert property (p_disc) else $error("no disconnect on empty");
  a_minFill: assert property (p_minFill) else $error("early reconnect");
  a_full: assert property (p_full) else $error("no reconnect at 512");
  a_round: assert property (p_round) else $error("threshold not 512 aligned");
  a_spare: assert property (p_spare) else $error("spare sector missing");
endmodule : disk_pages_checker
bind disk_reconnect_format_pages disk_pages_checker #(.LEN_W(LEN_W)) chk_u (.clk(clk),
  .rstn(rstn), .pageCode(pageCode), .byteAddr(byteAddr), .rdEn(rdEn), .wrEn(wrEn),
  .rdValid(rdValid), .wrIgnored(wrIgnored), .readActive(readActive), .bufLevel(bufLevel),
  .xferRemain(xferRemain), .disconnectReq(disconnectReq), .reconnectReq(reconnectReq),
  .fillBytes(fillBytes), .drainBytes(drainBytes), .formatActive(formatActive),
  .zoneSectors(zoneSectors), .userSectors(userSectors));

// *** test/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic clk, rstn, rdEn, wrEn, rdValid, rdErr, wrIgnored, readActive, writeActive;
  logic disconnectReq, reconnectReq, formatActive;
  logic [5:0] pageCode;
  logic [4:0] byteAddr;
  logic [7:0] wrData, rdData, d;
  logic [31:0] bufLevel, bufFree, xferRemain, fillBytes, drainBytes;
  logic [15:0] zoneSectors, userSectors;
  logic e;
  int failCount = 0;
  int cmpCount = 0;
  localparam logic [7:0] FMT [24] = '{8'h03, 8'h16, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h01, 8'h00, 8'h1c, 8'h00, 8'h20,
    8'h40, 8'h00, 8'h00, 8'h00};
  disk_reconnect_format_pages dut_u (.clk(clk), .rstn(rstn), .pageCode(pageCode),
    .byteAddr(byteAddr), .rdEn(rdEn), .wrEn(wrEn), .wrData(wrData), .rdData(rdData),
    .rdValid(rdValid), .rdErr(rdErr), .wrIgnored(wrIgnored), .readActive(readActive),
    .writeActive(writeActive), .bufLevel(bufLevel), .bufFree(bufFree),
    .xferRemain(xferRemain), .disconnectReq(disconnectReq), .reconnectReq(reconnectReq),
    .fillBytes(fillBytes), .drainBytes(drainBytes), .formatActive(formatActive),
    .zoneSectors(zoneSectors), .userSectors(userSectors));
  initiator_model ini_u (.clk(clk), .pageCode(pageCode), .byteAddr(byteAddr), .rdEn(rdEn),
    .wrEn(wrEn), .wrData(wrData), .rdData(rdData), .rdValid(rdValid), .rdErr(rdErr),
    .wrIgnored(wrIgnored));
  // ==========
  // helpers
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmpCount++;
    if (g !== x) begin
      failCount++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic drive(input logic r, input logic w, input logic [31:0] l, input logic [31:0] f);
    @(posedge clk);
    #1;
    readActive = r;
    writeActive = w;
    bufLevel = l;
    bufFree = f;
    @(posedge clk);
    #1;
  endtask : drive
  task automatic wrapUp();
    if (failCount == 0 && cmpCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrapUp
  // ==========
  // scenarios
  task automatic pageScan();
    for (int i = 0; i < 12; i++) begin
      ini_u.rd(6'h02, 5'(i), d, e);
      chk("reconByte", (i == 0) ? 32'h02 : (i == 1) ? 32'h0a : 32'h00, {24'h0, d});
    end
    for (int i = 0; i < 24; i++) begin
      ini_u.rd(6'h03, 5'(i), d, e);
      chk("fmtByte", {24'h0, FMT[i]}, {24'h0, d});
    end
    ini_u.rd(6'h02, 5'h0c, d, e);
    chk("rdErr", 32'h1, {31'h0, e});
  endtask : pageScan
  task automatic ratioRw();
    ini_u.wr(6'h02, 5'h02, 8'h81, e);
    chk("fillIgn", 32'h0, {31'h0, e});
    ini_u.wr(6'h02, 5'h03, 8'h81, e);
    ini_u.rd(6'h02, 5'h03, d, e);
    chk("drainBack", 32'h81, {24'h0, d});
    ini_u.rd(6'h02, 5'h02, d, e);
    chk("fillBack", 32'h81, {24'h0, d});
    ini_u.wr(6'h03, 5'h02, 8'h55, e);
    chk("fmtIgn", 32'h1, {31'h0, e});
    ini_u.rd(6'h03, 5'h03, d, e);
    chk("fmtKeep", 32'h04, {24'h0, d});
    ini_u.wr(6'h02, 5'h04, 8'hff, e);
    ini_u.rd(6'h02, 5'h04, d, e);
    chk("rsvdKeep", 32'h00, {24'h0, d});
    chk("fillBytes", 32'h8000, fillBytes);
    chk("drainBytes", 32'h8200, drainBytes);
  endtask : ratioRw
  task automatic reconnect();
    drive(1'b1, 1'b0, 32'd0, 32'd0);
    chk("disc", 32'h1, {31'h0, disconnectReq});
    drive(1'b1, 1'b0, 32'd511, 32'd0);
    chk("recon511", 32'h0, {31'h0, reconnectReq});
    drive(1'b1, 1'b0, 32'd512, 32'd0);
    chk("recon512", 32'h1, {31'h0, reconnectReq});
    drive(1'b0, 1'b1, 32'd0, 32'd512);
    chk("reconWr", 32'h1, {31'h0, reconnectReq});
    drive(1'b0, 1'b0, 32'd0, 32'd0);
  endtask : reconnect
  task automatic formatSpare();
    @(posedge clk);
    #1;
    formatActive = 1'b1;
    zoneSectors = 16'h0040;
    repeat (2) @(posedge clk);
    #1;
    formatActive = 1'b0;
    chk("userSectors", 32'h3f, {16'h0, userSectors});
  endtask : formatSpare
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    failCount++;
    wrapUp();
  end
  initial begin
    {rstn, readActive, writeActive, formatActive} = 4'h0;
    {bufLevel, bufFree, zoneSectors} = '0;
    xferRemain = 32'd4096;
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    pageScan();
    ratioRw();
    reconnect();
    formatSpare();
    wrapUp();
  end
endmodule : tb
